// ==== svs_regs.vh ====
// constants of the serial voltage-code slave: boot codes, prefix, voltage scale
// assumes it is included once per design file by bare name
// What this block does
// - the processor alone masters the link, driving clock and data
// - start, stop, bits and acknowledge follow fast-mode two-wire signalling
// - serial mode at enable rise latches clock and data pins as boot code
// - soft-start then brings both rails to the boot code level
// - boot codes 00..11 give 1.1/1.0/0.9/0.8V, debug 1.4/1.2/1.0/0.8V
// - latched boot code is kept and reused at every power-ok drop
// - with both rails regulated, raise power-good, then await power-ok
// - without power-ok, hold boot code; link commands are acknowledged but not acted on
// - while power-ok holds, link commands with address 110b and write bit are accepted and acted on
// - master sends start, address, write bit; slave acknowledges
// - one data byte follows, slave acknowledges, master sends stop
// - command takes effect only after stop, on each addressed rail
// - address bits 6:4 are 110b; bits 3 and 2 are ignored
// - address bit 1 selects core, bit 0 uncore, both for both
// - data bit 7 is active-low light-load flag allowing power saving
// - code gives 1.5500V minus 0.0125V per step; 7C..7F switch off
// - one rail may go off or on while power-good stays high
// - at enable rise, type select low means serial, high parallel
// - power-ok drop lowers power-good, rails to boot code until regulated
// - debug mode follows clock/data pins as static levels, ignores power-ok
`ifndef SVS_REGS_VH
`define SVS_REGS_VH
`define SVS_ADDR_PREFIX 3'h6
`define SVS_CODE_OFF_MIN 7'h7C
`define SVS_CODE_OFF 7'h7F
`define SVS_BOOT_00 7'h24
`define SVS_BOOT_01 7'h2C
`define SVS_BOOT_10 7'h34
`define SVS_BOOT_11 7'h3C
`define SVS_FIX_00 7'h0C
`define SVS_FIX_01 7'h1C
`define SVS_FIX_10 7'h2C
`define SVS_FIX_11 7'h3C
`define SVS_V_BASE 16'h3C8C
`define SVS_V_STEP 16'h007D
`define SVS_BYTE_BITS 4'h8
`define SVS_SYNC_W 8
`endif

// ==== svs_sync2.v ====
// two-flop synchroniser for a bundle of independent asynchronous levels
// assumes each bit is a slow level; no bit-to-bit coherence is promised
`timescale 1ns/1ps
module svs_sync2 #(
	parameter W = 1
) (
	input wire clk,
	input wire rst_b,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_r;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // svs_sync2

// ==== svs_code_volt.v ====
// maps a 7-bit voltage code to a target in units of 0.1 mV
// assumes the caller registers the result before driving a pin
`timescale 1ns/1ps
`include "svs_regs.vh"
module svs_code_volt (
	input wire [6:0] code,
	output wire off,
	output wire [15:0] tenth_mv
);
	wire [15:0] drop;
	assign off = (code >= `SVS_CODE_OFF_MIN);
	assign drop = {9'h000, code} * `SVS_V_STEP;
	assign tenth_mv = off ? 16'h0000 : (`SVS_V_BASE - drop);
endmodule // svs_code_volt

// ==== svs_slave.v ====
// serial voltage-code slave: start-up sequencing, send-byte receiver, rail codes
// assumes all pin inputs are asynchronous and the analog side reports regulation
`timescale 1ns/1ps
`include "svs_regs.vh"
module svs_slave (
	input wire clk,
	input wire rst_b,
	input wire enable,
	input wire cpu_type_select,
	input wire fixed_mode_select,
	input wire serial_code_clock,
	input wire serial_code_data_in,
	output reg serial_code_data_out,
	output reg serial_code_data_oe,
	input wire processor_power_ok,
	input wire core_in_regulation,
	input wire uncore_in_regulation,
	output reg regulator_power_good,
	output reg serial_mode,
	output reg soft_start_active,
	output reg light_load_flag_n,
	output reg [6:0] core_voltage_code,
	output reg [6:0] uncore_voltage_code,
	output reg core_rail_on,
	output reg uncore_rail_on,
	output reg [15:0] core_target,
	output reg [15:0] uncore_target
);

	// ****************************************
	// state encodings
	// ****************************************
	localparam ST_OFF = 7'h01;
	localparam ST_PAR = 7'h02;
	localparam ST_SOFT = 7'h04;
	localparam ST_WAIT = 7'h08;
	localparam ST_RUN = 7'h10;
	localparam ST_RECOV = 7'h20;
	localparam ST_FIX = 7'h40;
	localparam LK_IDLE = 7'h01;
	localparam LK_ADDR = 7'h02;
	localparam LK_AACK = 7'h04;
	localparam LK_DATA = 7'h08;
	localparam LK_DACK = 7'h10;
	localparam LK_DONE = 7'h20;
	localparam LK_SKIP = 7'h40;
	// ****************************************
	// pin synchronisation
	// ****************************************
	wire [`SVS_SYNC_W-1:0] pins_s;
	wire en_s;
	wire cpu_s;
	wire fix_s;
	wire scl_s;
	wire sda_s;
	wire pok_s;
	wire crdy_s;
	wire urdy_s;
	svs_sync2 #(
		.W(`SVS_SYNC_W)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d({enable, cpu_type_select, fixed_mode_select, serial_code_clock,
			serial_code_data_in, processor_power_ok, core_in_regulation,
			uncore_in_regulation}),
		.q(pins_s)
	);
	assign en_s = pins_s[7];
	assign cpu_s = pins_s[6];
	assign fix_s = pins_s[5];
	assign scl_s = pins_s[4];
	assign sda_s = pins_s[3];
	assign pok_s = pins_s[2];
	assign crdy_s = pins_s[1];
	assign urdy_s = pins_s[0];
	// ****************************************
	// edge detection on synchronised levels
	// ****************************************
	reg en_d_r;
	reg scl_d_r;
	reg sda_d_r;
	wire en_rise;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_d_r <= 1'b0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			en_d_r <= en_s;
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end
	assign en_rise = en_s & ~en_d_r;
	// link clock is sampled; 160 ns period leaves ~16 samples per bit
	assign scl_rise = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
	// ****************************************
	// code tables
	// ****************************************
	reg [1:0] boot_code_r;
	reg [6:0] boot_vcode;
	reg [6:0] pin_boot_vcode;
	reg [6:0] fix_vcode;
	always @* begin
		case (boot_code_r)
			2'h0: boot_vcode = `SVS_BOOT_00;
			2'h1: boot_vcode = `SVS_BOOT_01;
			2'h2: boot_vcode = `SVS_BOOT_10;
			default: boot_vcode = `SVS_BOOT_11;
		endcase
		case ({scl_s, sda_s})
			2'h0: pin_boot_vcode = `SVS_BOOT_00;
			2'h1: pin_boot_vcode = `SVS_BOOT_01;
			2'h2: pin_boot_vcode = `SVS_BOOT_10;
			default: pin_boot_vcode = `SVS_BOOT_11;
		endcase
		case ({scl_s, sda_s})
			2'h0: fix_vcode = `SVS_FIX_00;
			2'h1: fix_vcode = `SVS_FIX_01;
			2'h2: fix_vcode = `SVS_FIX_10;
			default: fix_vcode = `SVS_FIX_11;
		endcase
	end

	// ****************************************
	// link receiver (send byte)
	// ****************************************
	reg [6:0] lk_r;
	reg [3:0] bit_cnt_r;
	reg [7:0] shift_r;
	reg [1:0] rail_sel_r;
	reg [7:0] data_r;
	reg pend_r;
	reg cmd_go_r;
	wire link_en;
	wire addr_ok;
	// the link is decoded while serial_mode is set and debug select is low; only ST_RUN acts on it
	assign link_en = serial_mode & ~fix_s;
	// byte holds address bits 6:0 in [7:1] and the write bit in [0]
	assign addr_ok = (shift_r[7:5] == `SVS_ADDR_PREFIX) & ~shift_r[0];
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lk_r <= LK_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			rail_sel_r <= 2'h0;
			data_r <= 8'h00;
			pend_r <= 1'b0;
			cmd_go_r <= 1'b0;
			serial_code_data_oe <= 1'b0;
			serial_code_data_out <= 1'b0;
		end else begin
			cmd_go_r <= 1'b0;
			serial_code_data_out <= 1'b0;
			if (!link_en) begin
				lk_r <= LK_IDLE;
				pend_r <= 1'b0;
				serial_code_data_oe <= 1'b0;
			end else if (bus_start) begin
				// repeated start also restarts the address phase
				lk_r <= LK_ADDR;
				bit_cnt_r <= 4'h0;
				pend_r <= 1'b0;
				serial_code_data_oe <= 1'b0;
			end else if (bus_stop) begin
				cmd_go_r <= pend_r;
				pend_r <= 1'b0;
				lk_r <= LK_IDLE;
				serial_code_data_oe <= 1'b0;
			end else begin
				case (lk_r)
					LK_ADDR: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_s};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end else if (scl_fall && bit_cnt_r == `SVS_BYTE_BITS) begin
							if (addr_ok) begin
								serial_code_data_oe <= 1'b1;
								rail_sel_r <= shift_r[2:1];
								lk_r <= LK_AACK;
							end else begin
								lk_r <= LK_SKIP;
							end
						end
					end
					LK_AACK: begin
						if (scl_fall) begin
							serial_code_data_oe <= 1'b0;
							bit_cnt_r <= 4'h0;
							lk_r <= LK_DATA;
						end
					end
					LK_DATA: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_s};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end else if (scl_fall && bit_cnt_r == `SVS_BYTE_BITS) begin
							data_r <= shift_r;
							serial_code_data_oe <= 1'b1;
							lk_r <= LK_DACK;
						end
					end
					LK_DACK: begin
						if (scl_fall) begin
							serial_code_data_oe <= 1'b0;
							pend_r <= 1'b1;
							lk_r <= LK_DONE;
						end
					end
					LK_DONE: begin
						// a second data byte is not acknowledged
						lk_r <= LK_DONE;
					end
					LK_SKIP: begin
						lk_r <= LK_SKIP;
					end
					default: begin
						lk_r <= LK_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// start-up sequencer and rail codes
	// ****************************************
	reg [6:0] st_r;
	wire both_rdy;
	wire core_off;
	wire uncore_off;
	wire [15:0] core_mv;
	wire [15:0] uncore_mv;

	assign both_rdy = crdy_s & urdy_s;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= ST_OFF;
			boot_code_r <= 2'h0;
			serial_mode <= 1'b0;
			soft_start_active <= 1'b0;
			regulator_power_good <= 1'b0;
			light_load_flag_n <= 1'b1;
			core_voltage_code <= `SVS_CODE_OFF;
			uncore_voltage_code <= `SVS_CODE_OFF;
		end else if (!en_s) begin
			st_r <= ST_OFF;
			serial_mode <= 1'b0;
			soft_start_active <= 1'b0;
			regulator_power_good <= 1'b0;
			light_load_flag_n <= 1'b1;
			core_voltage_code <= `SVS_CODE_OFF;
			uncore_voltage_code <= `SVS_CODE_OFF;
		end else begin
			case (st_r)
				ST_OFF: begin
					if (en_rise) begin
						if (fix_s) begin
							// debug mode overrides the type select
							serial_mode <= 1'b1;
							st_r <= ST_FIX;
						end else if (cpu_s) begin
							st_r <= ST_PAR;
						end else begin
							serial_mode <= 1'b1;
							boot_code_r <= {scl_s, sda_s};
							core_voltage_code <= pin_boot_vcode;
							uncore_voltage_code <= pin_boot_vcode;
							soft_start_active <= 1'b1;
							st_r <= ST_SOFT;
						end
					end
				end
				ST_PAR: begin
					st_r <= ST_PAR;
				end
				ST_SOFT: begin
					if (both_rdy) begin
						soft_start_active <= 1'b0;
						regulator_power_good <= 1'b1;
						st_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// pending link commands are dropped here
					if (pok_s) begin
						st_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!pok_s) begin
						regulator_power_good <= 1'b0;
						core_voltage_code <= boot_vcode;
						uncore_voltage_code <= boot_vcode;
						light_load_flag_n <= 1'b1;
						st_r <= ST_RECOV;
					end else if (cmd_go_r) begin
						// power-good is held high when a rail goes on or off
						if (rail_sel_r[1]) begin
							core_voltage_code <= data_r[6:0];
						end
						if (rail_sel_r[0]) begin
							uncore_voltage_code <= data_r[6:0];
						end
						if (rail_sel_r != 2'h0) begin
							light_load_flag_n <= data_r[7];
						end
						regulator_power_good <= 1'b1;
					end
				end
				ST_RECOV: begin
					// relies on the analog side dropping regulation on a move
					if (both_rdy) begin
						regulator_power_good <= 1'b1;
						st_r <= ST_WAIT;
					end
				end
				ST_FIX: begin
					core_voltage_code <= fix_vcode;
					uncore_voltage_code <= fix_vcode;
					regulator_power_good <= both_rdy;
				end
				default: begin
					st_r <= ST_OFF;
				end
			endcase
		end
	end

	// ****************************************
	// code to voltage, registered to the pins
	// ****************************************
	svs_code_volt u_core_volt (
		.code(core_voltage_code),
		.off(core_off),
		.tenth_mv(core_mv)
	);

	svs_code_volt u_uncore_volt (
		.code(uncore_voltage_code),
		.off(uncore_off),
		.tenth_mv(uncore_mv)
	);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			core_rail_on <= 1'b0;
			uncore_rail_on <= 1'b0;
			core_target <= 16'h0000;
			uncore_target <= 16'h0000;
		end else begin
			core_rail_on <= ~core_off;
			uncore_rail_on <= ~uncore_off;
			core_target <= core_mv;
			uncore_target <= uncore_mv;
		end
	end

endmodule // svs_slave

// ==== svs_slave_properties.sv ====
// checker on the slave pins: acknowledge, power-good and rail outputs
// assumes pins change only at clk rise and a 160 ns link clock
`timescale 1ns/1ps
module svs_slave_properties (
	input wire clk,
	input wire rst_b,
	input wire fixed_mode_select,
	input wire serial_code_clock,
	input wire serial_code_data_out,
	input wire serial_code_data_oe,
	input wire processor_power_ok,
	input wire core_in_regulation,
	input wire uncore_in_regulation,
	input wire regulator_power_good,
	input wire serial_mode,
	input wire soft_start_active,
	input wire [6:0] core_voltage_code,
	input wire core_rail_on,
	input wire [15:0] core_target
);
	// ***********************
	// properties
	// ***********************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	open_drain_a: assert property (!serial_code_data_out)
		else $error("data line driven high");
	ack_low_a: assert property ($rose(serial_code_data_oe) |-> !serial_code_clock)
		else $error("ack started with clock high");
	ack_len_a: assert property ($rose(serial_code_data_oe) |=>
		serial_code_data_oe[*8] ##[1:12] !serial_code_data_oe) else $error("ack length wrong");
	fix_quiet_a: assert property (fixed_mode_select |-> !serial_code_data_oe)
		else $error("ack in debug mode");
	pg_fall_a: assert property ($fell(processor_power_ok) && !fixed_mode_select
		|-> ##[1:4] !regulator_power_good) else $error("power good kept");
	pg_reg_a: assert property ($rose(regulator_power_good)
		|-> core_in_regulation && uncore_in_regulation) else $error("power good early");
	rail_on_a: assert property (core_rail_on == ($past(core_voltage_code) < 7'h7C))
		else $error("rail on wrong");
	tgt_val_a: assert property (core_target == (core_rail_on ?
		16'h3C8C - 16'h007D * $past(core_voltage_code) : 16'h0000)) else $error("target wrong");
	soft_on_a: assert property ($rose(serial_mode) && !fixed_mode_select
		|-> soft_start_active) else $error("no soft start");
endmodule // svs_slave_properties
bind svs_slave svs_slave_properties i_props (.clk(clk), .rst_b(rst_b),
	.fixed_mode_select(fixed_mode_select), .serial_code_clock(serial_code_clock),
	.serial_code_data_out(serial_code_data_out), .serial_code_data_oe(serial_code_data_oe),
	.processor_power_ok(processor_power_ok), .core_in_regulation(core_in_regulation),
	.uncore_in_regulation(uncore_in_regulation), .regulator_power_good(regulator_power_good),
	.serial_mode(serial_mode), .soft_start_active(soft_start_active),
	.core_voltage_code(core_voltage_code), .core_rail_on(core_rail_on), .core_target(core_target));

// ==== svs_master.sv ====
// link master model: drives clock and data, samples the slave acks
// assumes a pull-up on data, so driving 1 means released
`timescale 1ns/1ps
module svs_master (
	input wire clk,
	input wire sda,
	output reg scl = 1'b1,
	output reg sda_o = 1'b1
);
	// ***********************
	// wire timing
	// ***********************
	// quarter link period, 40 ns
	task q;
		repeat (4) @(posedge clk);
	endtask
	// static levels for boot and debug codes
	task pins(input [1:0] p);
		begin
			scl <= p[1];
			sda_o <= p[0];
		end
	endtask
	task bit_io(input b, output r);
		begin
			q;
			sda_o <= b;
			q;
			scl <= 1'b1;
			q;
			r = sda;
			q;
			scl <= 1'b0;
		end
	endtask
	task send(input [7:0] a, input [7:0] d, output ka, output kd);
		integer i;
		reg r;
		begin
			@(posedge clk);
			sda_o <= 1'b0;
			q;
			scl <= 1'b0;
			for (i = 7; i >= 0; i = i - 1)
				bit_io(a[i], r);
			bit_io(1'b1, r);
			ka = !r;
			for (i = 7; i >= 0; i = i - 1)
				bit_io(d[i], r);
			bit_io(1'b1, r);
			kd = !r;
			q;
			sda_o <= 1'b0;
			q;
			scl <= 1'b1;
			q;
			sda_o <= 1'b1;
			q;
		end
	endtask
endmodule // svs_master

// ==== testbench.sv ====
// testbench: boots the slave, sends link commands, checks rail outputs
// assumes the master model owns the link pins between boots
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg en = 1'b0;
	reg cts = 1'b0;
	reg fix = 1'b0;
	reg ppo = 1'b0;
	reg [1:0] rg = 2'b00;
	reg a0, a1;
	reg [2:0] k;
	integer err_total = 0;
	integer cmp_count = 0;
	wire scl, sdo, sda, oe, dout, pg, smode, llf, con, uon;
	wire [6:0] cc, uc;
	wire [15:0] ct, ut;
	wire [27:0] bt = {7'h3C, 7'h34, 7'h2C, 7'h24};
	wire [27:0] fx = {7'h3C, 7'h2C, 7'h1C, 7'h0C};
	// open-drain wire with pull-up
	assign sda = sdo & (~oe | dout);
	initial forever #5 clk = ~clk;
	svs_master i_mst (.clk(clk), .sda(sda), .scl(scl), .sda_o(sdo));
	svs_slave i_dut (.clk(clk), .rst_b(rst_b), .enable(en), .cpu_type_select(cts),
		.fixed_mode_select(fix), .serial_code_clock(scl), .serial_code_data_in(sda),
		.serial_code_data_out(dout), .serial_code_data_oe(oe), .processor_power_ok(ppo),
		.core_in_regulation(rg[1]), .uncore_in_regulation(rg[0]), .regulator_power_good(pg),
		.serial_mode(smode), .soft_start_active(), .light_load_flag_n(llf),
		.core_voltage_code(cc), .uncore_voltage_code(uc), .core_rail_on(con), .uncore_rail_on(uon),
		.core_target(ct), .uncore_target(ut));
	// ***********************
	// tasks
	// ***********************
	task end_of_test;
		begin
			$display("checks %0d errors %0d", cmp_count, err_total);
			if (err_total == 0 && cmp_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input [55:0] n, input [15:0] e, input [15:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("unexpected %0s exp %h got %h", n, e, g);
			end
		end
	endtask
	task wpg(input e);
		integer i;
		begin
			for (i = 0; i < 60 && pg !== e; i = i + 1)
				@(negedge clk);
			chk("pgood", e, pg);
			if (pg !== e)
				end_of_test;
			else
				@(posedge clk);
		end
	endtask
	task boot(input [1:0] p, input f, input t);
		begin
			@(posedge clk);
			en <= 1'b0;
			ppo <= 1'b0;
			fix <= f;
			cts <= t;
			i_mst.pins(p);
			repeat (8) @(posedge clk);
			en <= 1'b1;
			repeat (8) @(posedge clk);
		end
	endtask
	task cmd(input [7:0] a, input [7:0] d, input e);
		begin
			i_mst.send(a, d, a0, a1);
			chk("ack", {e, e}, {a0, a1});
			repeat (6) @(posedge clk);
		end
	endtask
	// ***********************
	// sequence
	// ***********************
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		for (k = 0; k < 4; k = k + 1) begin
			boot(k[1:0], 1'b0, 1'b0);
			chk("core", bt[k*7 +: 7], cc);
			chk("uncore", bt[k*7 +: 7], uc);
		end
		rg <= 2'b01;
		repeat (10) @(posedge clk);
		chk("pgood", 1'b0, pg);
		rg <= 2'b11;
		wpg(1'b1);
		i_mst.pins(2'b11);
		ppo <= 1'b1;
		repeat (6) @(posedge clk);
		cmd(8'hC4, 8'h90, 1'b1);
		chk("core", 7'h10, cc);
		chk("uncore", 7'h3C, uc);
		chk("target", 16'h34BC, ct);
		cmd(8'hDA, 8'h05, 1'b1);
		chk("uncore", 7'h05, uc);
		chk("flag", 1'b0, llf);
		chk("utarget", 16'h3A1B, ut);
		cmd(8'hC4, 8'hFC, 1'b1);
		chk("rail", 1'b0, con);
		chk("pgood", 1'b1, pg);
		chk("uon", 1'b1, uon);
		cmd(8'hC2, 8'hFE, 1'b1);
		chk("uon", 1'b0, uon);
		chk("utarget", 16'h0000, ut);
		cmd(8'hC6, 8'h80, 1'b1);
		chk("target", 16'h3C8C, ct);
		chk("uncore", 7'h00, uc);
		chk("utarget", 16'h3C8C, ut);
		chk("uon", 1'b1, uon);
		chk("flag", 1'b1, llf);
		cmd(8'hE2, 8'h20, 1'b0);
		chk("uncore", 7'h00, uc);
		cmd(8'hC7, 8'h20, 1'b0);
		chk("uncore", 7'h00, uc);
		@(posedge clk);
		ppo <= 1'b0;
		rg <= 2'b00;
		wpg(1'b0);
		repeat (2) @(posedge clk);
		chk("core", 7'h3C, cc);
		cmd(8'hC6, 8'h10, 1'b1);
		chk("uncore", 7'h3C, uc);
		rg <= 2'b11;
		wpg(1'b1);
		boot(2'b11, 1'b0, 1'b1);
		chk("smode", 1'b0, smode);
		cmd(8'hC6, 8'h10, 1'b0);
		boot(2'b00, 1'b1, 1'b0);
		for (k = 0; k < 4; k = k + 1) begin
			i_mst.pins(k[1:0]);
			repeat (6) @(posedge clk);
			chk("core", fx[k*7 +: 7], cc);
		end
		wpg(1'b1);
		end_of_test;
	end
endmodule // testbench
